/* File: design/conv_trigger_control_map.svh */
// Register offsets, field positions, reset values and timing counts for the converter control block.
// Assumes an 8-bit internal CPU bus that presents the low 16 address bits.
`ifndef CONV_TRIGGER_CONTROL_MAP_SVH
`define CONV_TRIGGER_CONTROL_MAP_SVH

// ==========================================================================
// Register addresses
`define CONV_TRIGGER_CONTROL_RES_A_HI     16'hFFE0
`define CONV_TRIGGER_CONTROL_RES_A_LO     16'hFFE1
`define CONV_TRIGGER_CONTROL_RES_B_HI     16'hFFE2
`define CONV_TRIGGER_CONTROL_RES_B_LO     16'hFFE3
`define CONV_TRIGGER_CONTROL_RES_C_HI     16'hFFE4
`define CONV_TRIGGER_CONTROL_RES_C_LO     16'hFFE5
`define CONV_TRIGGER_CONTROL_RES_D_HI     16'hFFE6
`define CONV_TRIGGER_CONTROL_RES_D_LO     16'hFFE7
`define CONV_TRIGGER_CONTROL_CTRL_STAT    16'hFFE8
`define CONV_TRIGGER_CONTROL_TRIG_CTRL    16'hFFE9

// ==========================================================================
// Field positions
`define CONV_TRIGGER_CONTROL_CS_DONE      7
`define CONV_TRIGGER_CONTROL_CS_IRQ_EN    6
`define CONV_TRIGGER_CONTROL_CS_START     5
`define CONV_TRIGGER_CONTROL_CS_SCAN      4
`define CONV_TRIGGER_CONTROL_CS_CLK_SEL   3
`define CONV_TRIGGER_CONTROL_TC_TRG_EN    7

// ==========================================================================
// Reset values
`define CONV_TRIGGER_CONTROL_CS_RESET     8'h00
`define CONV_TRIGGER_CONTROL_TC_RESET     8'h7E
`define CONV_TRIGGER_CONTROL_TC_ONES      8'h7E

// ==========================================================================
// Timing: conversion length in states for slow and fast clock select
`define CONV_TRIGGER_CONTROL_CONV_SLOW    9'h10A
`define CONV_TRIGGER_CONTROL_CONV_FAST    9'h086

`endif

/* File: design/conv_trigger_control_pkg.sv */
// Types shared by the converter control block.
// Assumes the constants header is included where offsets are needed.
package conv_trigger_control_pkg;

    // ======================================================================
    // CPU bus request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } conv_trigger_control_bus_req_t;

    // Request to the analog core and its answer
    typedef struct packed {
        logic       sample;
        logic [2:0] channel;
    } conv_trigger_control_core_req_t;

    typedef struct packed {
        logic       valid;
        logic [9:0] data;
    } conv_trigger_control_core_rsp_t;

    // Sequencer states
    typedef enum logic [2:0] {
        CONV_TRIGGER_CONTROL_IDLE = 3'b001,
        CONV_TRIGGER_CONTROL_CONV = 3'b010,
        CONV_TRIGGER_CONTROL_NEXT = 3'b100
    } conv_trigger_control_state_t;

endpackage

/* File: design/conv_trigger_control_top.sv */
// Control and result storage around an eight-input ten-bit converter core.
// Assumes the core returns a result on core_rsp_i while a sample is requested.
`timescale 1ns/1ns
`include "conv_trigger_control_map.svh"
module conv_trigger_control_top (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    standby_i,
    input  wire logic                    module_stop_i,
    // CPU bus
    input  wire conv_trigger_control_pkg::conv_trigger_control_bus_req_t bus_i,
    output logic [7:0]                   rdata_o,
    // External trigger
    input  wire logic                    ext_conv_trigger_i,
    // Analog core
    input  wire conv_trigger_control_pkg::conv_trigger_control_core_rsp_t core_rsp_i,
    output conv_trigger_control_pkg::conv_trigger_control_core_req_t     core_req_o,
    output logic                         core_power_o,
    // Interrupt
    output logic                         conv_end_irq_o
);
    import conv_trigger_control_pkg::*;

    // ======================================================================
    // State
    logic [9:0]  result_q [4];
    logic [7:0]  temp_q;
    logic        done_q;
    logic        irq_en_q;
    logic        start_q;
    logic        scan_q;
    logic        clk_sel_q;
    logic [2:0]  chan_sel_q;
    logic        trg_en_q;
    logic        tc_bit0_q;
    logic        done_seen_q;
    logic        trg_s1_q;
    logic        trg_s2_q;
    logic        trg_s3_q;
    logic [8:0]  cnt_q;
    logic [1:0]  scan_idx_q;
    conv_trigger_control_state_t state_q;
    logic        clear;
    logic        trg_fall;
    logic        conv_end;
    logic        single_end;
    logic [2:0]  cur_chan;
    logic [8:0]  conv_len;
    logic        done_set;
    logic        ctrl_wr;
    logic        ctrl_rd;
    logic        trig_wr;

    // Byte image of a result register half
    function automatic logic [7:0] res_byte(input logic [9:0] r, input logic hi);
        res_byte = hi ? r[9:2] : {r[1:0], 6'h00};
    endfunction

    function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    // True for the eight result-register byte addresses
    function automatic logic is_res(input logic [15:0] a);
        is_res = (a[15:3] == `CONV_TRIGGER_CONTROL_RES_A_HI >> 3);
    endfunction

    // Standby and module stop both clear the block
    assign clear      = standby_i | module_stop_i;
    assign trg_fall   = trg_s3_q & ~trg_s2_q;
    assign conv_len   = clk_sel_q ? `CONV_TRIGGER_CONTROL_CONV_FAST : `CONV_TRIGGER_CONTROL_CONV_SLOW;
    assign cur_chan   = {chan_sel_q[2], scan_q ? scan_idx_q : chan_sel_q[1:0]};
    assign conv_end   = (state_q == CONV_TRIGGER_CONTROL_CONV) && core_rsp_i.valid;
    assign single_end = conv_end && !scan_q;
    // Scan sets the flag only after the last selected channel
    assign done_set   = single_end || (conv_end && scan_q && (scan_idx_q == chan_sel_q[1:0]));
    assign ctrl_wr    = bus_i.wr && is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_CTRL_STAT);
    assign ctrl_rd    = bus_i.rd && is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_CTRL_STAT);
    assign trig_wr    = bus_i.wr && is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_TRIG_CTRL);

    // Trigger synchroniser
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trg_s1_q <= 1'b1;
            trg_s2_q <= 1'b1;
            trg_s3_q <= 1'b1;
        end else begin
            trg_s1_q <= ext_conv_trigger_i;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
        end
    end

    // Interrupt enable bit of the control/status register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_en_q <= 1'b0;
        end else if (clear) begin
            irq_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            irq_en_q <= bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_IRQ_EN];
        end
    end

    // Scan mode bit; change it only while stopped
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scan_q <= 1'b0;
        end else if (clear) begin
            scan_q <= 1'b0;
        end else if (ctrl_wr) begin
            scan_q <= bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_SCAN];
        end
    end

    // Clock select bit, picks the conversion length
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_sel_q <= 1'b0;
        end else if (clear) begin
            clk_sel_q <= 1'b0;
        end else if (ctrl_wr) begin
            clk_sel_q <= bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_CLK_SEL];
        end
    end

    // Channel select; the top bit picks the input group
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_sel_q <= 3'h0;
        end else if (clear) begin
            chan_sel_q <= 3'h0;
        end else if (ctrl_wr) begin
            chan_sel_q <= bus_i.wdata[2:0];
        end
    end

    // Start bit: software, trigger edge, auto clear at single end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_q <= 1'b0;
        end else if (clear) begin
            start_q <= 1'b0;
        end else if (bus_i.wr && is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_CTRL_STAT)) begin
            start_q <= bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_START];
        end else if (trg_en_q && trg_fall && !start_q) begin
            start_q <= 1'b1;
        end else if (single_end) begin
            start_q <= 1'b0;
        end
    end

    // Done flag: set wins over clear; clear needs a prior read as one
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q <= 1'b0;
        end else if (clear) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (ctrl_wr && !bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_DONE] && done_seen_q) begin
            done_q <= 1'b0;
        end
    end

    // Remembers that software has read the flag as one
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_seen_q <= 1'b0;
        end else if (clear || done_set) begin
            done_seen_q <= 1'b0;
        end else if (ctrl_wr && !bus_i.wdata[`CONV_TRIGGER_CONTROL_CS_DONE]) begin
            done_seen_q <= 1'b0;
        end else if (ctrl_rd && done_q) begin
            done_seen_q <= 1'b1;
        end
    end

    // Trigger enable bit of the trigger control register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trg_en_q <= 1'b0;
        end else if (clear) begin
            trg_en_q <= 1'b0;
        end else if (trig_wr) begin
            trg_en_q <= bus_i.wdata[`CONV_TRIGGER_CONTROL_TC_TRG_EN];
        end
    end

    // Reserved low bit keeps what was written
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tc_bit0_q <= 1'b0;
        end else if (clear) begin
            tc_bit0_q <= 1'b0;
        end else if (trig_wr) begin
            tc_bit0_q <= bus_i.wdata[0];
        end
    end

    // Conversion sequencer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= CONV_TRIGGER_CONTROL_IDLE;
            cnt_q      <= 9'h000;
            scan_idx_q <= 2'h0;
        end else if (clear || !start_q) begin
            state_q    <= CONV_TRIGGER_CONTROL_IDLE;
            cnt_q      <= 9'h000;
            scan_idx_q <= 2'h0;
        end else begin
            case (state_q)
                CONV_TRIGGER_CONTROL_IDLE: begin
                    state_q <= CONV_TRIGGER_CONTROL_CONV;
                    cnt_q   <= 9'h000;
                end
                CONV_TRIGGER_CONTROL_CONV: begin
                    if (cnt_q != conv_len) begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                    if (conv_end) begin
                        state_q <= scan_q ? CONV_TRIGGER_CONTROL_NEXT : CONV_TRIGGER_CONTROL_IDLE;
                    end
                end
                CONV_TRIGGER_CONTROL_NEXT: begin
                    // Scan wraps after the last selected channel
                    scan_idx_q <= (scan_idx_q == chan_sel_q[1:0]) ? 2'h0
                                                                  : scan_idx_q + 2'h1;
                    cnt_q      <= 9'h000;
                    state_q    <= CONV_TRIGGER_CONTROL_CONV;
                end
                default: state_q <= CONV_TRIGGER_CONTROL_IDLE;
            endcase
        end
    end

    // Result storage by channel pair
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 4; i++) result_q[i] <= 10'h000;
        end else if (clear) begin
            for (int i = 0; i < 4; i++) result_q[i] <= 10'h000;
        end else if (conv_end) begin
            result_q[cur_chan[1:0]] <= core_rsp_i.data;
        end
    end

    // Temporary byte, loaded with the low half on an upper-byte read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_q <= 8'h00;
        end else if (clear) begin
            temp_q <= 8'h00;
        end else if (bus_i.rd && is_res(bus_i.addr) && !bus_i.addr[0]) begin
            temp_q <= res_byte(result_q[bus_i.addr[2:1]], 1'b0);
        end
    end

    // Read data, registered and held until the next read; standby or module stop clears it to zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (clear) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            if (is_res(bus_i.addr)) begin
                if (!bus_i.addr[0]) begin
                    rdata_o <= res_byte(result_q[bus_i.addr[2:1]], 1'b1);
                end else begin
                    rdata_o <= temp_q;
                end
            end else if (is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_CTRL_STAT)) begin
                rdata_o <= {done_q, irq_en_q, start_q, scan_q, clk_sel_q, chan_sel_q};
            end else if (is_addr(bus_i.addr, `CONV_TRIGGER_CONTROL_TRIG_CTRL)) begin
                rdata_o <= {trg_en_q, 7'h00} | `CONV_TRIGGER_CONTROL_TC_ONES | {7'h00, tc_bit0_q};
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    // Sample request and channel to the core
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_req_o <= '0;
        end else begin
            core_req_o.sample  <= (state_q == CONV_TRIGGER_CONTROL_CONV) && !clear && start_q;
            core_req_o.channel <= cur_chan;
        end
    end

    // Core power is the registered inverse of the module stop input
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_power_o <= 1'b0;
        end else begin
            core_power_o <= !module_stop_i;
        end
    end

    // Interrupt level; standby or stop drop it at the same edge as the flag
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conv_end_irq_o <= 1'b0;
        end else begin
            conv_end_irq_o <= done_q && irq_en_q && !clear;
        end
    end

endmodule

/* File: dv/conv_trigger_control_chk_asserts.sv */
// Port-level checker for conv_trigger_control_top.
// Assumes it is bound to conv_trigger_control_top and sees only its ports.
`timescale 1ns/1ns
module conv_trigger_control_chk (
    // Clock and modes
    input wire logic                     mclk_i,
    input wire logic                     nrst_i,
    input wire logic                     standby_i,
    input wire logic                     module_stop_i,
    // Bus, trigger, core and interrupt
    input wire conv_trigger_control_pkg::conv_trigger_control_bus_req_t  bus_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     ext_conv_trigger_i,
    input wire conv_trigger_control_pkg::conv_trigger_control_core_rsp_t core_rsp_i,
    input wire conv_trigger_control_pkg::conv_trigger_control_core_req_t core_req_o,
    input wire logic                     core_power_o,
    input wire logic                     conv_end_irq_o
);
    import conv_trigger_control_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ==================================================================
    // Assertions
    stop_power_a: assert property (module_stop_i |=> !core_power_o)
        else $error("core power kept in stop");
    run_power_a: assert property (nrst_i && !module_stop_i |=> core_power_o)
        else $error("core power missing");
    halt_idle_a: assert property ((standby_i || module_stop_i) |=> !core_req_o.sample)
        else $error("sampling after standby");
    stby_irq_a: assert property (standby_i |=> !conv_end_irq_o)
        else $error("interrupt after standby");
    low_zero_a: assert property (bus_i.rd && bus_i.addr[15:3] == 13'h1FFC && bus_i.addr[0]
        |=> rdata_o[5:0] == 6'h00)
        else $error("low result bits not zero");
    trig_ones_a: assert property (bus_i.rd && bus_i.addr == 16'hFFE9 |=> rdata_o[6:1] == 6'h3F)
        else $error("trigger control ones wrong");
    hold_data_a: assert property (!bus_i.rd && !standby_i && !module_stop_i
        |=> $stable(rdata_o))
        else $error("read data changed");
    irq_cause_a: assert property ($rose(conv_end_irq_o) |-> $past(core_rsp_i.valid, 2))
        else $error("interrupt without result");
    unmap_zero_a: assert property (bus_i.rd && (bus_i.addr < 16'hFFE0 || bus_i.addr > 16'hFFE9)
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Main scenarios
    cover property ($rose(conv_end_irq_o));
    cover property ($fell(ext_conv_trigger_i));
    cover property (standby_i);
endmodule
bind conv_trigger_control_top conv_trigger_control_chk u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .standby_i(standby_i),
    .module_stop_i(module_stop_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .ext_conv_trigger_i(ext_conv_trigger_i), .core_rsp_i(core_rsp_i),
    .core_req_o(core_req_o), .core_power_o(core_power_o), .conv_end_irq_o(conv_end_irq_o));

/* File: dv/conv_trigger_control_core_model.sv */
// Behavioural analog core: answers one result per sampling request.
// Assumes the bench sets delay and level; result carries the channel.
`timescale 1ns/1ns
module conv_trigger_control_core_model (
    // Clock and reset
    input wire logic                     mclk_i,
    input wire logic                     nrst_i,
    // Request, timing and level
    input wire conv_trigger_control_pkg::conv_trigger_control_core_req_t req_i,
    input wire logic [7:0]               dly_i,
    input wire logic [6:0]               lvl_i,
    output conv_trigger_control_pkg::conv_trigger_control_core_rsp_t     rsp_o
);
    import conv_trigger_control_pkg::*;
    logic [7:0] cnt_q;
    logic [9:0] last_q;
    // Count while sampling; data shows inverse of last result when idle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            last_q <= 10'h000;
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= 1'b0;
            rsp_o.data <= ~last_q;
            if (!req_i.sample) cnt_q <= 8'h00;
            else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
            if (req_i.sample && cnt_q == dly_i) begin
                rsp_o.valid <= 1'b1;
                rsp_o.data <= {req_i.channel, lvl_i};
                last_q <= {req_i.channel, lvl_i};
            end
        end
    end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for conv_trigger_control_top with the analog core model.
// Assumes design files and conv_trigger_control_core_model are compiled first.
`timescale 1ns/1ns
`include "conv_trigger_control_map.svh"
module tb_top;
    import conv_trigger_control_pkg::*;
    logic           mclk_i = 1'b0;
    logic           nrst_i = 1'b0;
    logic           standby_i = 1'b0;
    logic           module_stop_i = 1'b0;
    logic           ext_conv_trigger_i = 1'b1;
    conv_trigger_control_bus_req_t  bus_i = '0;
    logic [7:0]     rdata_o;
    conv_trigger_control_core_rsp_t core_rsp_i;
    conv_trigger_control_core_req_t core_req_o;
    logic           core_power_o;
    logic           conv_end_irq_o;
    logic [7:0]     dly = 8'h05;
    logic [6:0]     lvl = 7'h00;
    logic           rd_p = 1'b0;
    logic [7:0]     exp_q[$];
    logic [9:0]     res;
    int             errors = 0;
    int             total_checks = 0;

    always #25 mclk_i = ~mclk_i;

    conv_trigger_control_top u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .standby_i(standby_i),
        .module_stop_i(module_stop_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .ext_conv_trigger_i(ext_conv_trigger_i), .core_rsp_i(core_rsp_i),
        .core_req_o(core_req_o), .core_power_o(core_power_o), .conv_end_irq_o(conv_end_irq_o));
    conv_trigger_control_core_model u_core (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(core_req_o),
        .dly_i(dly), .lvl_i(lvl), .rsp_o(core_rsp_i));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One bus cycle: held for one edge, then released
    task automatic bus(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus_i <= {r, ~r, a, d};
        @(posedge mclk_i);
        bus_i <= '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 8'h00);
    endtask

    task automatic wait_irq();
        for (int n = 0; conv_end_irq_o !== 1'b1; n++) begin
            @(posedge mclk_i);
            #1;
            if (n > 400) begin
                errors++;
                print_verdict();
            end
        end
    endtask

    task automatic res_chk(input logic [1:0] p, input logic [9:0] v);
        rd({13'h1FFC, p, 1'b0}, v[9:2]);
        rd({13'h1FFC, p, 1'b1}, {v[1:0], 6'h00});
    endtask

    task automatic reg_reads();
        for (int a = 0; a < 11; a++) begin
            rd(16'hFFE0 + 16'(a), (a == 9) ? 8'h7E : 8'h00);
        end
    endtask

    // Compare each read answer with the oldest note
    always @(posedge mclk_i) rd_p <= bus_i.rd;
    always @(negedge mclk_i) begin
        if (rd_p) check(rdata_o, exp_q.pop_front());
    end

    initial begin
        void'($urandom(13));
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        bus(1'b0, `CONV_TRIGGER_CONTROL_RES_A_HI, 8'hFF);
        reg_reads();
        // Single conversions on every input
        for (int c = 0; c < 8; c++) begin
            dly <= 8'(5 + $urandom_range(35));
            lvl <= 7'($urandom);
            bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h60 | 8'(c));
            wait_irq();
            res = {3'(c), lvl};
            if (c == 3) bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h43);
            rd(`CONV_TRIGGER_CONTROL_CTRL_STAT, 8'hC0 | 8'(c));
            bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h40 | 8'(c));
            bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'hC0 | 8'(c));
            rd(`CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h40 | 8'(c));
            check({7'h00, conv_end_irq_o}, 8'h00);
            res_chk(res[8:7], res);
        end
        // Scan over inputs 0 and 1 with the fast clock select, then stop
        lvl <= 7'($urandom);
        bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h79);
        wait_irq();
        bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h59);
        rd(`CONV_TRIGGER_CONTROL_CTRL_STAT, 8'hD9);
        bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h41);
        res_chk(2'd0, {3'd0, lvl});
        res_chk(2'd1, {3'd1, lvl});
        // Start by falling edge of the external trigger
        bus(1'b0, `CONV_TRIGGER_CONTROL_TRIG_CTRL, 8'h80);
        rd(`CONV_TRIGGER_CONTROL_TRIG_CTRL, 8'hFE);
        bus(1'b0, `CONV_TRIGGER_CONTROL_CTRL_STAT, 8'h46);
        lvl <= 7'h55;
        ext_conv_trigger_i <= 1'b0;
        wait_irq();
        @(posedge mclk_i);
        ext_conv_trigger_i <= 1'b1;
        rd(`CONV_TRIGGER_CONTROL_CTRL_STAT, 8'hC6);
        res_chk(2'd2, {3'd6, 7'h55});
        // Standby and converter stop clear state
        @(posedge mclk_i);
        standby_i <= 1'b1;
        module_stop_i <= 1'b1;
        @(posedge mclk_i);
        standby_i <= 1'b0;
        module_stop_i <= 1'b0;
        reg_reads();
        repeat (3) @(posedge mclk_i);
        print_verdict();
    end
endmodule
